// ---- sar_adc_conversion_control.sv ----
// conversion control for the 12-bit successive-approximation converter
//
// How it works
// - source code 0000 routes the pin chosen by the channel field to the converter.
// - source codes 0100 and 11xx also select an external pin, like 0000.
// - any internal source disconnects every external pin regardless of channel field.
// - internal codes pick supply, half, quarter supply or reference, half, quarter.
// - source codes 10xx tie the converter input to analog ground.
// - writing start high then low launches one conversion.
// - busy clears when the conversion completes.
// - completion sets the request flag; interrupt raised only if both enables are set.
// - conversion clock is system clock divided by two to the divider code.
// - four periods sampling then twelve periods converting, sixteen in all.
// - converter analog circuitry is powered only while power enable is high.
// - conversion runs on its own without processor involvement.
// - result lands in high and low bytes before busy clears.
// - analog pin function overrides the pin's port direction setting.
// - alignment 0 gives bits 11..4 high; 1 gives bits 11..8 high.
// - reference code 00 supply, 01 reference pin, 1x amplified reference.
// - with power off the result registers keep their contents.
//
// Local design decisions: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module sar_adc_conversion_control
  import sar_adc_pkg::*;
(
  // clock, reset, enable
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // analog front end
  input wire logic cmp_above,
  output route_s route,
  output logic adc_power,
  output logic sample_en,
  output logic [11:0] dac_code,
  output logic [3:0] pin_dir_override,
  // interrupt toward the converter vector
  output logic irq_req
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic start_r;
  logic power_r;
  logic align_r;
  logic [3:0] chan_r;
  logic [3:0] src_r;
  logic [2:0] div_r;
  logic [7:0] ctrl2_r;
  logic [7:0] res_high_r;
  logic [7:0] res_low_r;
  logic gie_r;
  logic cie_r;
  logic flag_r;
  logic [3:0] pinfn_r;
  logic armed_r;
  logic busy_r;
  conv_state_e state_r;
  logic [6:0] div_cnt_r;
  logic [3:0] period_r;
  logic [11:0] sar_r;

  // ----------------------------------------------------------------
  // bus slave: writes zero-wait, reads take one wait state
  // ----------------------------------------------------------------
  logic wr_pend_r;
  logic rd_pend_r;
  logic [7:0] addr_r;
  logic hreadyout_r;
  logic [31:0] hrdata_r;
  logic addr_phase;
  logic wr_now;
  logic [7:0] wdat;
  logic [31:0] rd_mux;

  assign addr_phase = hsel && htrans[1] && hready;
  assign wr_now = wr_pend_r;
  assign wdat = hwdata[7:0];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      addr_r <= 8'h00;
      hreadyout_r <= 1'b1;
      hrdata_r <= 32'h00000000;
    end else if (ce) begin
      wr_pend_r <= addr_phase && hwrite;
      rd_pend_r <= addr_phase && !hwrite;
      if (addr_phase) begin
        addr_r <= haddr[7:0];
      end
      if (addr_phase && !hwrite) begin
        hreadyout_r <= 1'b0;
      end else if (rd_pend_r) begin
        hreadyout_r <= 1'b1;
        hrdata_r <= rd_mux;
      end
    end
  end

  // unmapped addresses read zero and ignore writes
  always_comb begin
    rd_mux = 32'h00000000;
    case (addr_r)
      ADDR_CTRL0: begin
        rd_mux[7:0] = {start_r, busy_r, power_r, align_r, chan_r};
      end
      ADDR_CTRL1: begin
        rd_mux[7:0] = {src_r, 1'b0, div_r};
      end
      ADDR_CTRL2: begin
        rd_mux[7:0] = ctrl2_r;
      end
      ADDR_RES_HIGH: begin
        rd_mux[7:0] = res_high_r;
      end
      ADDR_RES_LOW: begin
        rd_mux[7:0] = res_low_r;
      end
      ADDR_INTC: begin
        rd_mux[2:0] = {flag_r, cie_r, gie_r};
      end
      ADDR_PINFN: begin
        rd_mux[3:0] = pinfn_r;
      end
      default: begin
        rd_mux = 32'h00000000;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  logic wr_ctrl0;
  logic start_req;

  assign wr_ctrl0 = wr_now && (addr_r == ADDR_CTRL0);
  // falling write of start after an armed rising write; busy blocks it
  assign start_req = wr_ctrl0 && armed_r && !wdat[C0_START] && !busy_r && power_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      start_r <= RST_CTRL0[C0_START];
      power_r <= RST_CTRL0[C0_POWER];
      align_r <= RST_CTRL0[C0_ALIGN];
      chan_r <= RST_CTRL0[3:0];
      armed_r <= 1'b0;
    end else if (ce && wr_ctrl0) begin
      start_r <= wdat[C0_START];
      power_r <= wdat[C0_POWER];
      align_r <= wdat[C0_ALIGN];
      chan_r <= wdat[C0_CHAN_LSB +: 4];
      armed_r <= wdat[C0_START] && !start_r;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      src_r <= RST_CTRL1[7:4];
      div_r <= RST_CTRL1[2:0];
    end else if (ce && wr_now && (addr_r == ADDR_CTRL1)) begin
      src_r <= wdat[C1_SRC_LSB +: 4];
      div_r <= wdat[C1_DIV_LSB +: 3];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl2_r <= RST_CTRL2;
    end else if (ce && wr_now && (addr_r == ADDR_CTRL2)) begin
      ctrl2_r <= {wdat[7], 2'b00, wdat[4:0]};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pinfn_r <= RST_PINFN;
    end else if (ce && wr_now && (addr_r == ADDR_PINFN)) begin
      pinfn_r <= wdat[3:0];
    end
  end

  // ----------------------------------------------------------------
  // completion flag and interrupt request
  // ----------------------------------------------------------------
  logic done_evt;

  assign done_evt = (state_r == ST_DONE);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gie_r <= RST_INTC[IC_GIE];
      cie_r <= RST_INTC[IC_CIE];
      flag_r <= RST_INTC[IC_FLAG];
    end else if (ce) begin
      if (wr_now && (addr_r == ADDR_INTC)) begin
        gie_r <= wdat[IC_GIE];
        cie_r <= wdat[IC_CIE];
        flag_r <= wdat[IC_FLAG];
      end
      // set beats a simultaneous software clear
      if (done_evt) begin
        flag_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_req <= 1'b0;
    end else if (ce) begin
      irq_req <= (flag_r || done_evt) && gie_r && cie_r;
    end
  end

  // ----------------------------------------------------------------
  // conversion clock divider
  // ----------------------------------------------------------------
  logic [6:0] div_last;
  logic tick;

  assign div_last = 7'((8'h01 << div_r) - 8'h01);
  assign tick = (div_cnt_r == div_last);

  // runs only during a conversion so every conversion starts phase-aligned
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_cnt_r <= 7'h00;
    end else if (ce) begin
      if (!busy_r || tick) begin
        div_cnt_r <= 7'h00;
      end else begin
        div_cnt_r <= div_cnt_r + 7'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // sequencer: sample, successive approximation, result
  // ----------------------------------------------------------------
  logic [11:0] trial;
  logic [11:0] result;

  // sar_r holds decided bits plus the bit under test
  assign trial = sar_r;
  assign result = cmp_above ? sar_r : (sar_r & ~(12'h800 >> period_r));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= ST_IDLE;
      period_r <= 4'h0;
      sar_r <= 12'h000;
    end else if (ce) begin
      case (state_r)
        ST_IDLE: begin
          if (start_req) begin
            state_r <= ST_SAMPLE;
            period_r <= 4'h0;
            sar_r <= 12'h800;
          end
        end
        ST_SAMPLE: begin
          if (!power_r) begin
            state_r <= ST_IDLE;
          end else if (tick) begin
            if (period_r == SAMPLE_LAST) begin
              state_r <= ST_CONVERT;
              period_r <= 4'h0;
            end else begin
              period_r <= period_r + 4'h1;
            end
          end
        end
        ST_CONVERT: begin
          if (!power_r) begin
            state_r <= ST_IDLE;
          end else if (tick) begin
            // one result bit per conversion-clock period, msb first
            sar_r <= result | ((12'h800 >> period_r) >> 1);
            if (period_r == CONVERT_LAST) begin
              sar_r <= result;
              state_r <= ST_DONE;
            end else begin
              period_r <= period_r + 4'h1;
            end
          end
        end
        ST_DONE: begin
          state_r <= ST_IDLE;
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // busy covers the whole sequence including the result cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy_r <= 1'b0;
    end else if (ce) begin
      if (start_req) begin
        busy_r <= 1'b1;
      end else if (done_evt || (busy_r && !power_r)) begin
        busy_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // result placement, written one cycle before busy drops
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      res_high_r <= RST_RESULT;
      res_low_r <= RST_RESULT;
    end else if (ce && power_r && (state_r == ST_CONVERT) && tick
                 && (period_r == CONVERT_LAST)) begin
      if (align_r) begin
        res_high_r <= {4'h0, result[11:8]};
        res_low_r <= result[7:0];
      end else begin
        res_high_r <= result[11:4];
        res_low_r <= {result[3:0], 4'h0};
      end
    end
  end

  // ----------------------------------------------------------------
  // analog routing
  // ----------------------------------------------------------------
  route_s route_nxt;
  logic ext_sel;

  // 0000, 0100 and 11xx all mean external pin
  assign ext_sel = (src_r == SRC_EXT) || (src_r == SRC_EXT_ALT)
                   || (src_r[3:2] == 2'b11);

  always_comb begin
    route_nxt = '0;
    route_nxt.int_src = INT_NONE;
    route_nxt.ref_src = REF_AVDD;
    if (ext_sel) begin
      case (chan_r)
        CH_AN0: route_nxt.ext_pin_en = 4'h1;
        CH_AN1: route_nxt.ext_pin_en = 4'h2;
        CH_AN6: route_nxt.ext_pin_en = 4'h4;
        CH_AN7: route_nxt.ext_pin_en = 4'h8;
        default: route_nxt.ext_pin_en = 4'h0;
      endcase
    end else if (src_r[3:2] == 2'b10) begin
      route_nxt.gnd_en = 1'b1;
    end else begin
      // pins stay off for every internal source
      case (src_r)
        SRC_AVDD: route_nxt.int_src = INT_AVDD;
        SRC_AVDD_2: route_nxt.int_src = INT_AVDD_2;
        SRC_AVDD_4: route_nxt.int_src = INT_AVDD_4;
        SRC_VR: route_nxt.int_src = INT_VR;
        SRC_VR_2: route_nxt.int_src = INT_VR_2;
        SRC_VR_4: route_nxt.int_src = INT_VR_4;
        default: route_nxt.int_src = INT_NONE;
      endcase
    end
    case (ctrl2_r[C2_REF_LSB +: 2])
      2'b00: route_nxt.ref_src = REF_AVDD;
      2'b01: route_nxt.ref_src = REF_PIN;
      default: route_nxt.ref_src = REF_PGA;
    endcase
    route_nxt.pga_en = ctrl2_r[C2_PGA_EN];
    route_nxt.pga_in_internal = ctrl2_r[C2_PGA_IN];
    route_nxt.pga_gain = ctrl2_r[C2_GAIN_LSB +: 2];
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      route <= '0;
      adc_power <= 1'b0;
      sample_en <= 1'b0;
      pin_dir_override <= 4'h0;
    end else if (ce) begin
      route <= route_nxt;
      adc_power <= power_r;
      sample_en <= (state_r == ST_SAMPLE);
      pin_dir_override <= pinfn_r;
    end
  end

  // straight off the trial register: at the undivided clock a tick follows every cycle
  assign dac_code = trial;
  assign hreadyout = hreadyout_r;
  assign hrdata = hrdata_r;
  assign hresp = 1'b0;

endmodule : sar_adc_conversion_control

`default_nettype wire

// ---- sar_adc_pkg.sv ----
// shared constants, types and register map of the converter control
package sar_adc_pkg;

  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL0 = 8'h00;
  localparam logic [7:0] ADDR_CTRL1 = 8'h04;
  localparam logic [7:0] ADDR_CTRL2 = 8'h08;
  localparam logic [7:0] ADDR_RES_HIGH = 8'h0C;
  localparam logic [7:0] ADDR_RES_LOW = 8'h10;
  localparam logic [7:0] ADDR_INTC = 8'h14;
  localparam logic [7:0] ADDR_PINFN = 8'h18;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int C0_START = 7;
  localparam int C0_BUSY = 6;
  localparam int C0_POWER = 5;
  localparam int C0_ALIGN = 4;
  localparam int C0_CHAN_LSB = 0;
  localparam int C1_SRC_LSB = 4;
  localparam int C1_DIV_LSB = 0;
  localparam int C2_PGA_EN = 7;
  localparam int C2_PGA_IN = 4;
  localparam int C2_REF_LSB = 2;
  localparam int C2_GAIN_LSB = 0;
  localparam int IC_GIE = 0;
  localparam int IC_CIE = 1;
  localparam int IC_FLAG = 2;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_CTRL0 = 8'h00;
  localparam logic [7:0] RST_CTRL1 = 8'h00;
  localparam logic [7:0] RST_CTRL2 = 8'h00;
  localparam logic [7:0] RST_RESULT = 8'h00;
  localparam logic [2:0] RST_INTC = 3'h0;
  localparam logic [3:0] RST_PINFN = 4'h0;

  // ----------------------------------------------------------------
  // timing counts in conversion-clock periods
  // ----------------------------------------------------------------
  localparam logic [3:0] SAMPLE_PERIODS = 4'h4;
  localparam logic [3:0] CONVERT_PERIODS = 4'hC;
  localparam logic [3:0] SAMPLE_LAST = 4'h3;
  localparam logic [3:0] CONVERT_LAST = 4'hB;

  // ----------------------------------------------------------------
  // source and channel codes
  // ----------------------------------------------------------------
  localparam logic [3:0] SRC_EXT = 4'h0;
  localparam logic [3:0] SRC_EXT_ALT = 4'h4;
  localparam logic [3:0] SRC_AVDD = 4'h1;
  localparam logic [3:0] SRC_AVDD_2 = 4'h2;
  localparam logic [3:0] SRC_AVDD_4 = 4'h3;
  localparam logic [3:0] SRC_VR = 4'h5;
  localparam logic [3:0] SRC_VR_2 = 4'h6;
  localparam logic [3:0] SRC_VR_4 = 4'h7;
  localparam logic [3:0] CH_AN0 = 4'h0;
  localparam logic [3:0] CH_AN1 = 4'h1;
  localparam logic [3:0] CH_AN6 = 4'h6;
  localparam logic [3:0] CH_AN7 = 4'h7;

  typedef enum logic [2:0] {
    INT_NONE = 3'b000,
    INT_AVDD = 3'b001,
    INT_AVDD_2 = 3'b010,
    INT_AVDD_4 = 3'b011,
    INT_VR = 3'b101,
    INT_VR_2 = 3'b110,
    INT_VR_4 = 3'b111
  } int_src_e;

  typedef enum logic [1:0] {
    REF_AVDD = 2'b00,
    REF_PIN = 2'b01,
    REF_PGA = 2'b10
  } ref_src_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SAMPLE = 2'b01,
    ST_CONVERT = 2'b10,
    ST_DONE = 2'b11
  } conv_state_e;

  // analog routing toward the switch matrix
  typedef struct packed {
    logic [3:0] ext_pin_en;
    int_src_e int_src;
    logic gnd_en;
    ref_src_e ref_src;
    logic pga_en;
    logic pga_in_internal;
    logic [1:0] pga_gain;
  } route_s;

endpackage : sar_adc_pkg

// ---- sar_adc_checker.sv ----
// port-level assertions for the converter control block
`timescale 1ns/1ps
`default_nettype none
module sar_adc_checker
  import sar_adc_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  // converter side
  input wire route_s route,
  input wire logic adc_power,
  input wire logic sample_en
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ----------------------------------------------------------------
  // helper logic
  // ----------------------------------------------------------------
  logic take;
  logic div_wr_r;
  logic [2:0] div_r;
  logic [9:0] hi_cnt_r;
  assign take = hsel && htrans[1] && hready;
  // shadow of the divider code, so the sample length can be predicted
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_wr_r <= 1'b0;
      div_r <= 3'h0;
    end else begin
      div_wr_r <= take && hwrite && haddr[7:0] == ADDR_CTRL1;
      if (div_wr_r) div_r <= hwdata[2:0];
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) hi_cnt_r <= 10'h000;
    else hi_cnt_r <= sample_en ? hi_cnt_r + 10'h001 : 10'h000;
  end
  sequence read_answer;
    !hreadyout ##1 hreadyout;
  endsequence
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_pins_one_hot: assert property ($onehot0(route.ext_pin_en))
    else $error("more than one analog pin routed");
  a_internal_isolates: assert property (
    route.int_src != INT_NONE |-> route.ext_pin_en == 4'h0 && !route.gnd_en)
    else $error("pin joined to internal source");
  a_ground_isolates: assert property (
    route.gnd_en |-> route.ext_pin_en == 4'h0 && route.int_src == INT_NONE)
    else $error("ground joined to another source");
  a_power_gates_sample: assert property ((!adc_power) [*2] |-> !sample_en)
    else $error("sampling while unpowered");
  a_start_needs_power: assert property ($rose(sample_en) |-> adc_power)
    else $error("conversion began unpowered");
  a_sample_length: assert property (
    $fell(sample_en) && adc_power |-> hi_cnt_r == (10'h004 << div_r))
    else $error("sampling length wrong");
  a_read_waits_once: assert property (take && !hwrite |=> read_answer)
    else $error("read answer timing wrong");
  a_write_no_wait: assert property (take && hwrite |=> hreadyout)
    else $error("write stalled");
endmodule : sar_adc_checker

bind sar_adc_conversion_control sar_adc_checker chk (
  .hclk(hclk),
  .hresetn(hresetn),
  .hsel(hsel),
  .haddr(haddr),
  .htrans(htrans),
  .hwrite(hwrite),
  .hwdata(hwdata),
  .hready(hready),
  .hreadyout(hreadyout),
  .route(route),
  .adc_power(adc_power),
  .sample_en(sample_en)
);
`default_nettype wire

// ---- analog_front_model.sv ----
// behavioural analog front end: selected level against the trial code
`timescale 1ns/1ps
`default_nettype none
module analog_front_model
  import sar_adc_pkg::*;
(
  // clock
  input wire logic hclk,
  // from the control block
  input wire route_s route,
  input wire logic adc_power,
  input wire logic [11:0] dac_code,
  // level on the external pin
  input wire logic [11:0] pin_level,
  // comparator
  output logic cmp_above
);
  logic [11:0] lvl;
  logic tog_r = 1'b0;
  always_ff @(posedge hclk) tog_r <= !tog_r;
  always_comb begin
    case (route.int_src)
      INT_AVDD: lvl = 12'hFFF;
      INT_AVDD_2: lvl = 12'h800;
      INT_AVDD_4: lvl = 12'h400;
      INT_VR: lvl = 12'hC00;
      INT_VR_2: lvl = 12'h600;
      INT_VR_4: lvl = 12'h300;
      // an unrouted input floats, so it wobbles
      default: lvl = route.gnd_en ? 12'h000 : |route.ext_pin_en ? pin_level : {12{tog_r}};
    endcase
  end
  // unpowered comparator output is meaningless
  assign cmp_above = adc_power ? (lvl >= dac_code) : tog_r;
endmodule : analog_front_model
`default_nettype wire

// ---- sar_adc_conversion_control_tb.sv ----
// self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin \
  num_checks++; \
  if ((g) !== (e)) begin \
    num_errors++; \
    $display("BAD t=%0t got %0h want %0h", $time, (g), (e)); \
  end \
end
module sar_adc_conversion_control_tb;
  import sar_adc_pkg::*;
  logic hclk = 1'b0;
  logic ce = 1'b1;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [11:0] pin_level = 12'h000;
  logic hreadyout, hresp, cmp_above, adc_power, sample_en, irq_req;
  logic [31:0] hrdata, q;
  logic [11:0] dac_code;
  logic [3:0] pin_dir_override;
  route_s route;
  int num_errors = 0;
  int num_checks = 0;
  int cyc = 0;
  always #20 hclk = ~hclk;
  always @(posedge hclk) cyc++;
  sar_adc_conversion_control uut (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .cmp_above(cmp_above), .route(route), .adc_power(adc_power),
    .sample_en(sample_en), .dac_code(dac_code),
    .pin_dir_override(pin_dir_override), .irq_req(irq_req));
  analog_front_model afe (
    .hclk(hclk), .route(route), .adc_power(adc_power), .dac_code(dac_code),
    .pin_level(pin_level), .cmp_above(cmp_above));
  // ----------------------------------------------------------------
  // bus tasks
  // ----------------------------------------------------------------
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    q = hrdata;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    `CHK(q, {24'h0, e})
  endtask : rd
  function automatic logic [15:0] place(input logic [11:0] v, input logic al);
    return al ? {4'h0, v} : {v, 4'h0};
  endfunction : place
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    logic [3:0] c;
    logic ext, gnd;
    logic [11:0] v;
    logic [15:0] p;
    int n, t;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    for (int a = 0; a < 8; a++) rd(8'(a * 4), 8'h00);
    wr(8'h1C, 8'hFF);
    rd(8'h1C, 8'h00);
    wr(ADDR_PINFN, 8'h0A);
    rd(ADDR_PINFN, 8'h0A);
    `CHK(pin_dir_override, 4'hA)
    ce <= 1'b0;
    wr(ADDR_PINFN, 8'h05);
    ce <= 1'b1;
    rd(ADDR_PINFN, 8'h0A);
    $display("test registers done");
    wr(ADDR_CTRL0, 8'h01);
    for (int s = 0; s < 16; s++) begin
      c = 4'(s);
      ext = c[3:2] == 2'b11 || (!c[3] && c[1:0] == 2'b00);
      gnd = c[3:2] == 2'b10;
      wr(ADDR_CTRL1, {c, 4'h0});
      repeat (2) @(posedge hclk);
      `CHK(route.ext_pin_en, ext ? 4'h2 : 4'h0)
      `CHK(route.gnd_en, gnd)
      `CHK(route.int_src, (ext || gnd) ? INT_NONE : int_src_e'(c[2:0]))
    end
    wr(ADDR_CTRL1, 8'h00);
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_CTRL0, {5'h0, i[1], i[1], i[0]});
      repeat (2) @(posedge hclk);
      `CHK(route.ext_pin_en, 4'h1 << i)
      wr(ADDR_CTRL2, {i[1], 2'b00, i[1], 2'(i), 2'(i)});
      repeat (2) @(posedge hclk);
      `CHK(route.ref_src, i[1] ? REF_PGA : ref_src_e'(2'(i)))
      `CHK({route.pga_en, route.pga_in_internal, route.pga_gain}, {i[1], i[1], 2'(i)})
    end
    $display("test routing done");
    for (int d = 0; d < 8; d++) begin
      c = d == 6 ? 4'h8 : d == 7 ? 4'h2 : 4'h0;
      v = d == 6 ? 12'h000 : d == 7 ? 12'h800 : 12'h3C5 + 12'(d * 12'h2A7);
      p = place(v, d[0]);
      n = 16 << d;
      pin_level <= v;
      wr(ADDR_CTRL1, {c, 1'b0, 3'(d)});
      wr(ADDR_INTC, {6'h0, d[0], d[0]});
      wr(ADDR_CTRL0, {3'h5, d[0], 4'h0});
      repeat (8) @(posedge hclk);
      wr(ADDR_CTRL0, {3'h1, d[0], 4'h0});
      t = cyc;
      rd(ADDR_CTRL0, {3'h3, d[0], 4'h0});
      do bus(1'b0, ADDR_CTRL0, 8'h00); while (q[C0_BUSY] === 1'b1 && cyc - t < 4000);
      `CHK(cyc - t >= n && cyc - t <= n + 9, 1'b1)
      rd(ADDR_RES_HIGH, p[15:8]);
      rd(ADDR_RES_LOW, p[7:0]);
      `CHK(hresp, 1'b0)
      rd(ADDR_INTC, {5'h1, d[0], d[0]});
      `CHK(irq_req, d[0])
      wr(ADDR_INTC, 8'h00);
      $display("test conversion div %0d done", d);
    end
    pin_level <= 12'h123;
    p = place(12'h123, 1'b0);
    wr(ADDR_CTRL1, 8'h00);
    wr(ADDR_CTRL0, 8'hA0);
    wr(ADDR_CTRL0, 8'h20);
    wr(ADDR_CTRL0, 8'hA0);
    wr(ADDR_CTRL0, 8'h20);
    t = cyc;
    do bus(1'b0, ADDR_CTRL0, 8'h00); while (q[C0_BUSY] === 1'b1 && cyc - t < 400);
    `CHK(cyc - t <= 17, 1'b1)
    rd(ADDR_CTRL0, 8'h20);
    rd(ADDR_RES_HIGH, p[15:8]);
    wr(ADDR_INTC, 8'h00);
    wr(ADDR_CTRL0, 8'h60);
    rd(ADDR_CTRL0, 8'h20);
    wr(ADDR_CTRL1, 8'h03);
    pin_level <= 12'hABC;
    wr(ADDR_CTRL0, 8'hA0);
    wr(ADDR_CTRL0, 8'h20);
    repeat (40) @(posedge hclk);
    wr(ADDR_CTRL0, 8'h00);
    rd(ADDR_CTRL0, 8'h00);
    `CHK(adc_power, 1'b0)
    rd(ADDR_RES_HIGH, p[15:8]);
    rd(ADDR_RES_LOW, p[7:0]);
    rd(ADDR_INTC, 8'h00);
    wr(ADDR_CTRL0, 8'h80);
    wr(ADDR_CTRL0, 8'h00);
    rd(ADDR_CTRL0, 8'h00);
    $display("test abort and refusals done");
    print_verdict();
  end
  initial begin
    #(40 * 40000);
    num_errors++;
    $display("BAD t=%0t watchdog expired", $time);
    print_verdict();
  end
endmodule : sar_adc_conversion_control_tb
`default_nettype wire
